// ===== rtl/ipb_priority_bank.sv
// What this block does
// - code 111 means level 7, highest
// - code 001 means level 1, lowest
// - code 000 disables the source
// - unimplemented bits read zero, ignore writes
// - every field resets to binary 100
// - without can, can sources stay disabled
// - reg 7: uart b tx/rx, irq b, timer five
// - reg 8: can event/receive, serial b event/error
// - reg 9: only dma three at 2-0
// - reg 11: dma four 10-8, parallel 6-4
// - reg 15: calendar 10-8, dma five 6-4
// - reg 16: checksum 14-12, uart b/a errors
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "ipb_params.svh"

module ipb_priority_bank
    import ipb_pkg::*;
#(
    parameter int ADDR_WIDTH = 7, // byte address bits seen
    parameter bit HAS_CAN = 1'b1 // variant carries a can controller
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // axi4-lite write address
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // effective levels, 0 = source disabled
    output logic [2:0] uartBTransmitPriority,
    output logic [2:0] uartBReceivePriority,
    output logic [2:0] externalIrqBPriority,
    output logic [2:0] timerFivePriority,
    output logic [2:0] canEventPriority,
    output logic [2:0] canReceiveReadyPriority,
    output logic [2:0] serialPeriphBEventPriority,
    output logic [2:0] serialPeriphBErrorPriority,
    output logic [2:0] dmaChThreeDonePriority,
    output logic [2:0] dmaChFourDonePriority,
    output logic [2:0] parallelPortPriority,
    output logic [2:0] calendarClockPriority,
    output logic [2:0] dmaChFiveDonePriority,
    output logic [2:0] checksumGenErrorPriority,
    output logic [2:0] uartBErrorPriority,
    output logic [2:0] uartAErrorPriority,
    // one bit per source, set when it may request
    output logic [15:0] sourceEnable
);

    // ****************************************
    // elaboration checks
    // ****************************************

    // the highest offset needs seven address bits
    if (ADDR_WIDTH < 7 || ADDR_WIDTH > 32) begin : gBadAddrWidth
        $error("ipb_priority_bank: ADDR_WIDTH must be 7..32");
    end

    // ****************************************
    // functions
    // ****************************************

    // byte address to register select
    function automatic ipb_sel_e decodeAddr(
        input logic [ADDR_WIDTH-1:0] addr
    );
        logic [6:0] low;
        low = addr[6:0];
        decodeAddr = SEL_MISS;
        // upper bits must be clear, no aliasing
        if ((addr >> 7) == '0) begin
            case (low)
                `IPB_OFF_STATUS: decodeAddr = SEL_STATUS;
                `IPB_OFF_R7: decodeAddr = SEL_R7;
                `IPB_OFF_R8: decodeAddr = SEL_R8;
                `IPB_OFF_R9: decodeAddr = SEL_R9;
                `IPB_OFF_R11: decodeAddr = SEL_R11;
                `IPB_OFF_R15: decodeAddr = SEL_R15;
                `IPB_OFF_R16: decodeAddr = SEL_R16;
                default: decodeAddr = SEL_MISS;
            endcase
        end
    endfunction : decodeAddr

    // implemented-bit mask of a priority register
    function automatic logic [15:0] implMask(
        input ipb_sel_e sel
    );
        case (sel)
            SEL_R7: implMask = `IPB_MASK_R7;
            SEL_R8: implMask = `IPB_MASK_R8;
            SEL_R9: implMask = `IPB_MASK_R9;
            SEL_R11: implMask = `IPB_MASK_R11;
            SEL_R15: implMask = `IPB_MASK_R15;
            SEL_R16: implMask = `IPB_MASK_R16;
            default: implMask = 16'h0000;
        endcase
    endfunction : implMask

    // storage slot of a priority register
    function automatic logic [2:0] slotOf(
        input ipb_sel_e sel
    );
        slotOf = 3'(sel) - 3'h1;
    endfunction : slotOf

    // field code to level: identity, 0 means off
    function automatic logic [2:0] fieldToLevel(
        input logic [15:0] word,
        input int lsb,
        input logic present
    );
        logic [2:0] code;
        code = word[lsb +: 3];
        // 111 -> 7, 001 -> 1, 010..110 -> 2..6
        fieldToLevel = present ? code : 3'h0;
    endfunction : fieldToLevel

    // ****************************************
    // state
    // ****************************************

    ipb_state_s state; // registered copy
    ipb_state_s next_state; // value for next edge

    logic awFire; // write address taken now
    logic wFire; // write data taken now
    logic arFire; // read address taken now
    logic [15:0] byteMask; // lanes chosen by strobes
    logic [15:0] writeMask; // lanes that really change
    logic [15:0] oldWord; // target word before write
    ipb_sel_e wrSel; // register of the pending write
    ipb_sel_e rdSel; // register of the new read
    logic [15:0] rdWord; // word returned on read

    // ****************************************
    // handshakes
    // ****************************************

    // one slot each; a stalled response stops intake
    assign s_axi_awready = !state.awHeld && !state.bValid;
    assign s_axi_wready = !state.wHeld && !state.bValid;
    assign s_axi_arready = !state.rValid;

    assign awFire = s_axi_awvalid && s_axi_awready;
    assign wFire = s_axi_wvalid && s_axi_wready;
    assign arFire = s_axi_arvalid && s_axi_arready;

    // ****************************************
    // next state
    // ****************************************

    // address and data may come in either order
    always_comb begin
        next_state = state;
        byteMask = 16'h0000;
        writeMask = 16'h0000;
        oldWord = 16'h0000;
        wrSel = SEL_MISS;
        rdSel = SEL_MISS;
        rdWord = 16'h0000;

        // capture write address as a select
        if (awFire) begin
            next_state.awSel = decodeAddr(s_axi_awaddr);
            next_state.awHeld = 1'b1;
        end
        // capture low half of write data
        if (wFire) begin
            next_state.wData = s_axi_wdata[15:0];
            next_state.wStrb = s_axi_wstrb[1:0];
            next_state.wHeld = 1'b1;
        end

        // both halves present: perform the write
        if (next_state.awHeld && next_state.wHeld) begin
            wrSel = next_state.awSel;
            byteMask = {{8{next_state.wStrb[1]}}, {8{next_state.wStrb[0]}}};
            // unimplemented bits never change
            writeMask = byteMask & implMask(wrSel);
            if (wrSel != SEL_MISS && wrSel != SEL_STATUS) begin
                oldWord = state.regs[slotOf(wrSel)];
                next_state.regs[slotOf(wrSel)] =
                    (oldWord & ~writeMask) | (next_state.wData & writeMask);
            end
            // status is read-only; writes to it are dropped quietly
            next_state.bResp = (wrSel == SEL_MISS) ? `IPB_RESP_SLVERR : `IPB_RESP_OKAY;
            next_state.bValid = 1'b1;
            next_state.awHeld = 1'b0;
            next_state.wHeld = 1'b0;
        end else if (state.bValid && s_axi_bready) begin
            // response taken
            next_state.bValid = 1'b0;
        end

        // read: data registered, valid next cycle
        if (arFire) begin
            rdSel = decodeAddr(s_axi_araddr);
            if (rdSel == SEL_STATUS) begin
                rdWord = sourceEnable;
            end else if (rdSel != SEL_MISS) begin
                // reserved bits forced to zero on read
                rdWord = state.regs[slotOf(rdSel)] & implMask(rdSel);
            end
            next_state.rData = {16'h0000, rdWord};
            next_state.rResp = (rdSel == SEL_MISS) ? `IPB_RESP_SLVERR : `IPB_RESP_OKAY;
            next_state.rValid = 1'b1;
        end else if (state.rValid && s_axi_rready) begin
            // read data taken
            next_state.rValid = 1'b0;
        end

        // synchronous reset: power-on values
        if (srst) begin
            next_state = '0;
            next_state.awSel = SEL_MISS;
            next_state.regs[slotOf(SEL_R7)] = `IPB_RST_R7;
            next_state.regs[slotOf(SEL_R8)] = `IPB_RST_R8;
            next_state.regs[slotOf(SEL_R9)] = `IPB_RST_R9;
            next_state.regs[slotOf(SEL_R11)] = `IPB_RST_R11;
            next_state.regs[slotOf(SEL_R15)] = `IPB_RST_R15;
            next_state.regs[slotOf(SEL_R16)] = `IPB_RST_R16;
        end
    end

    // ****************************************
    // register
    // ****************************************

    // every bit of state moves on every edge
    always_ff @(posedge clock) begin
        state <= next_state;
    end

    // ****************************************
    // bus outputs
    // ****************************************

    assign s_axi_bvalid = state.bValid;
    assign s_axi_bresp = state.bResp;
    assign s_axi_rvalid = state.rValid;
    assign s_axi_rdata = state.rData;
    assign s_axi_rresp = state.rResp;

    // ****************************************
    // effective levels
    // ****************************************

    // register 7 fields
    assign uartBTransmitPriority =
        fieldToLevel(state.regs[slotOf(SEL_R7)], `IPB_POS_HI, 1'b1);
    assign uartBReceivePriority =
        fieldToLevel(state.regs[slotOf(SEL_R7)], `IPB_POS_MH, 1'b1);
    assign externalIrqBPriority =
        fieldToLevel(state.regs[slotOf(SEL_R7)], `IPB_POS_ML, 1'b1);
    assign timerFivePriority =
        fieldToLevel(state.regs[slotOf(SEL_R7)], `IPB_POS_LO, 1'b1);

    // register 8 fields; can ones forced off without can
    assign canEventPriority =
        fieldToLevel(state.regs[slotOf(SEL_R8)], `IPB_POS_HI, HAS_CAN);
    assign canReceiveReadyPriority =
        fieldToLevel(state.regs[slotOf(SEL_R8)], `IPB_POS_MH, HAS_CAN);
    assign serialPeriphBEventPriority =
        fieldToLevel(state.regs[slotOf(SEL_R8)], `IPB_POS_ML, 1'b1);
    assign serialPeriphBErrorPriority =
        fieldToLevel(state.regs[slotOf(SEL_R8)], `IPB_POS_LO, 1'b1);

    // register 9 field
    assign dmaChThreeDonePriority =
        fieldToLevel(state.regs[slotOf(SEL_R9)], `IPB_POS_LO, 1'b1);

    // register 11 fields
    assign dmaChFourDonePriority =
        fieldToLevel(state.regs[slotOf(SEL_R11)], `IPB_POS_MH, 1'b1);
    assign parallelPortPriority =
        fieldToLevel(state.regs[slotOf(SEL_R11)], `IPB_POS_ML, 1'b1);

    // register 15 fields
    assign calendarClockPriority =
        fieldToLevel(state.regs[slotOf(SEL_R15)], `IPB_POS_MH, 1'b1);
    assign dmaChFiveDonePriority =
        fieldToLevel(state.regs[slotOf(SEL_R15)], `IPB_POS_ML, 1'b1);

    // register 16 fields
    assign checksumGenErrorPriority =
        fieldToLevel(state.regs[slotOf(SEL_R16)], `IPB_POS_HI, 1'b1);
    assign uartBErrorPriority =
        fieldToLevel(state.regs[slotOf(SEL_R16)], `IPB_POS_MH, 1'b1);
    assign uartAErrorPriority =
        fieldToLevel(state.regs[slotOf(SEL_R16)], `IPB_POS_LO + 4, 1'b1);

    // ****************************************
    // source enables
    // ****************************************

    // level zero means the source never requests
    assign sourceEnable = {
        uartAErrorPriority != 3'h0,
        uartBErrorPriority != 3'h0,
        checksumGenErrorPriority != 3'h0,
        dmaChFiveDonePriority != 3'h0,
        calendarClockPriority != 3'h0,
        parallelPortPriority != 3'h0,
        dmaChFourDonePriority != 3'h0,
        dmaChThreeDonePriority != 3'h0,
        serialPeriphBErrorPriority != 3'h0,
        serialPeriphBEventPriority != 3'h0,
        canReceiveReadyPriority != 3'h0,
        canEventPriority != 3'h0,
        timerFivePriority != 3'h0,
        externalIrqBPriority != 3'h0,
        uartBReceivePriority != 3'h0,
        uartBTransmitPriority != 3'h0
    };

    // prot bits carry no meaning here
    logic unusedProt;
    assign unusedProt = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:16], s_axi_wstrb[3:2]};

endmodule : ipb_priority_bank
`default_nettype wire

// ===== inc/ipb_params.svh
`ifndef IPB_PARAMS_SVH
`define IPB_PARAMS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define IPB_OFF_STATUS 7'h00
`define IPB_OFF_R7 7'h1c
`define IPB_OFF_R8 7'h20
`define IPB_OFF_R9 7'h24
`define IPB_OFF_R11 7'h2c
`define IPB_OFF_R15 7'h3c
`define IPB_OFF_R16 7'h40

// ****************************************
// implemented bits per register
// ****************************************
`define IPB_MASK_R7 16'h7777
`define IPB_MASK_R8 16'h7777
`define IPB_MASK_R9 16'h0007
`define IPB_MASK_R11 16'h0770
`define IPB_MASK_R15 16'h0770
`define IPB_MASK_R16 16'h7770

// ****************************************
// reset values, every field at 3'b100
// ****************************************
`define IPB_RST_R7 16'h4444
`define IPB_RST_R8 16'h4444
`define IPB_RST_R9 16'h0004
`define IPB_RST_R11 16'h0440
`define IPB_RST_R15 16'h0440
`define IPB_RST_R16 16'h4440

// ****************************************
// field low-bit positions
// ****************************************
`define IPB_POS_HI 12
`define IPB_POS_MH 8
`define IPB_POS_ML 4
`define IPB_POS_LO 0

// ****************************************
// bus answers
// ****************************************
`define IPB_RESP_OKAY 2'h0
`define IPB_RESP_SLVERR 2'h2

`endif

// ===== inc/ipb_pkg.sv
// ****************************************
// types of the priority bank
// ****************************************
package ipb_pkg;

    // register selected by an address
    typedef enum logic [2:0] {
        SEL_STATUS = 3'b000,
        SEL_R7 = 3'b001,
        SEL_R8 = 3'b010,
        SEL_R9 = 3'b011,
        SEL_R11 = 3'b100,
        SEL_R15 = 3'b101,
        SEL_R16 = 3'b110,
        SEL_MISS = 3'b111
    } ipb_sel_e;

    // whole state of the block
    typedef struct packed {
        ipb_sel_e awSel;
        logic awHeld;
        logic [15:0] wData;
        logic [1:0] wStrb;
        logic wHeld;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [5:0][15:0] regs;
    } ipb_state_s;

endpackage : ipb_pkg

// ===== bench/ipb_priority_bank_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "ipb_params.svh"
// ****
// watch on read-back fields and level enables
// ****
module ipb_priority_bank_checker
    import ipb_pkg::*;
#(
    parameter int ADDR_WIDTH = 7, // byte address bits seen
    parameter bit HAS_CAN = 1'b1 // variant carries a can controller
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // read side of the bus
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    // write answer and enables
    input wire logic s_axi_bvalid,
    input wire logic [15:0] sourceEnable
);
    logic [ADDR_WIDTH-1:0] arHeld; // address of the read under way
    logic [3:0] nz; // field nonzero, top field in bit 0 like the enables
    assign nz = {|s_axi_rdata[2:0], |s_axi_rdata[6:4], |s_axi_rdata[10:8], |s_axi_rdata[14:12]};
    // remember the read address until its answer comes
    always_ff @(posedge clock) begin
        if (srst) begin
            arHeld <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            arHeld <= s_axi_araddr;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // fresh answer, no write landing in the same cycle to skew the compare
    sequence s_back(logic [6:0] a);
        $rose(s_axi_rvalid) && !$rose(s_axi_bvalid) && s_axi_rresp == 2'h0 && arHeld == a;
    endsequence
    // status carries the enables, which fill all of bits 15:0, so it is left out here
    property p_spare_zero;
        s_axi_rvalid && arHeld != `IPB_OFF_STATUS |-> (s_axi_rdata & 32'hffff8888) == 32'h0;
    endproperty
    a_spare_zero: assert property (p_spare_zero) else $error("spare read bits set");
    property p_reset_level;
        disable iff (1'b0) srst |=> sourceEnable == (HAS_CAN ? 16'hffff : 16'hffcf);
    endproperty
    a_reset_level: assert property (p_reset_level) else $error("enables wrong after reset");
    property p_hold_levels;
        !$rose(s_axi_bvalid) |-> $stable(sourceEnable);
    endproperty
    a_hold_levels: assert property (p_hold_levels) else $error("enables moved without a write");
    property p_can_quiet;
        !HAS_CAN |-> sourceEnable[5:4] == 2'h0;
    endproperty
    a_can_quiet: assert property (p_can_quiet) else $error("can source enabled");
    property p_reg7;
        s_back(`IPB_OFF_R7) |-> sourceEnable[3:0] == nz;
    endproperty
    a_reg7: assert property (p_reg7) else $error("reg7 fields misplaced");
    property p_reg8;
        s_back(`IPB_OFF_R8) |-> sourceEnable[7:4] == {nz[3:2], HAS_CAN ? nz[1:0] : 2'h0};
    endproperty
    a_reg8: assert property (p_reg8) else $error("reg8 fields misplaced");
    property p_reg9;
        s_back(`IPB_OFF_R9) |-> sourceEnable[8] == nz[3];
    endproperty
    a_reg9: assert property (p_reg9) else $error("reg9 field misplaced");
    property p_reg11;
        s_back(`IPB_OFF_R11) |-> sourceEnable[10:9] == nz[2:1];
    endproperty
    a_reg11: assert property (p_reg11) else $error("reg11 fields misplaced");
    property p_reg15;
        s_back(`IPB_OFF_R15) |-> sourceEnable[12:11] == nz[2:1];
    endproperty
    a_reg15: assert property (p_reg15) else $error("reg15 fields misplaced");
    property p_reg16;
        s_back(`IPB_OFF_R16) |-> sourceEnable[15:13] == nz[2:0];
    endproperty
    a_reg16: assert property (p_reg16) else $error("reg16 fields misplaced");
endmodule : ipb_priority_bank_checker

bind ipb_priority_bank ipb_priority_bank_checker #(.ADDR_WIDTH(ADDR_WIDTH), .HAS_CAN(HAS_CAN)) chk (
    .clock(clock), .srst(srst), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid), .sourceEnable(sourceEnable)
);
`default_nettype wire

// ===== bench/ipb_priority_bank_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "ipb_params.svh"
// ****
// dut lacks can, so can sources must stay off; dutCan carries it and sees the same traffic
// ****
module ipb_priority_bank_bench import ipb_pkg::*;;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [6:0] awAddr = 7'h0, arAddr = 7'h0;
    logic [31:0] wData = 32'h0, rData;
    logic [3:0] wStrb = 4'h0;
    logic [2:0] prot = 3'h0; // ignored by the bank, randomised anyway
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic awReady, wReady, bValid, arReady, rValid;
    logic [1:0] bResp, rResp;
    logic [2:0] lv [16]; // levels in enable-bit order
    logic [15:0] srcEn;
    logic [2:0] lvCan [2]; // can levels of the variant with can
    logic [15:0] srcEnCan;
    logic [31:0] rDataCan;
    logic [15:0] model [6]; // expected register contents
    int failures = 0, checksDone = 0;
    // register and field low bit of each source
    localparam int SREG [16] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 3, 3, 4, 4, 5, 5, 5};
    localparam int SLSB [16] = '{12, 8, 4, 0, 12, 8, 4, 0, 0, 8, 4, 8, 4, 12, 8, 4};
    localparam logic [6:0] OFFS [6] = '{`IPB_OFF_R7, `IPB_OFF_R8, `IPB_OFF_R9,
        `IPB_OFF_R11, `IPB_OFF_R15, `IPB_OFF_R16};
    localparam logic [6:0] BAD [3] = '{7'h28, 7'h1d, `IPB_OFF_STATUS};
    localparam logic [1:0] BADR [3] = '{2'h2, 2'h2, 2'h0};
    ipb_priority_bank #(.ADDR_WIDTH(7), .HAS_CAN(1'b0)) dut (
        .clock(clock), .srst(srst), .s_axi_awaddr(awAddr), .s_axi_awprot(prot), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arprot(prot), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .uartBTransmitPriority(lv[0]), .uartBReceivePriority(lv[1]), .externalIrqBPriority(lv[2]),
        .timerFivePriority(lv[3]), .canEventPriority(lv[4]), .canReceiveReadyPriority(lv[5]),
        .serialPeriphBEventPriority(lv[6]), .serialPeriphBErrorPriority(lv[7]), .dmaChThreeDonePriority(lv[8]),
        .dmaChFourDonePriority(lv[9]), .parallelPortPriority(lv[10]), .calendarClockPriority(lv[11]),
        .dmaChFiveDonePriority(lv[12]), .checksumGenErrorPriority(lv[13]), .uartBErrorPriority(lv[14]),
        .uartAErrorPriority(lv[15]), .sourceEnable(srcEn)
    );
    // same inputs, so its handshakes move in step with dut's
    ipb_priority_bank #(.ADDR_WIDTH(7), .HAS_CAN(1'b1)) dutCan (
        .clock(clock), .srst(srst), .s_axi_awaddr(awAddr), .s_axi_awprot(prot), .s_axi_awvalid(awValid),
        .s_axi_awready(), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
        .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arprot(prot), .s_axi_arvalid(arValid), .s_axi_arready(),
        .s_axi_rdata(rDataCan), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rReady),
        .uartBTransmitPriority(), .uartBReceivePriority(), .externalIrqBPriority(), .timerFivePriority(),
        .canEventPriority(lvCan[0]), .canReceiveReadyPriority(lvCan[1]), .serialPeriphBEventPriority(),
        .serialPeriphBErrorPriority(), .dmaChThreeDonePriority(), .dmaChFourDonePriority(),
        .parallelPortPriority(), .calendarClockPriority(), .dmaChFiveDonePriority(),
        .checksumGenErrorPriority(), .uartBErrorPriority(), .uartAErrorPriority(), .sourceEnable(srcEnCan)
    );
    // fields of register r all set to f; f=7 gives the implemented bits
    function automatic logic [15:0] implBits(int r, logic [2:0] f);
        implBits = 16'h0;
        for (int i = 0; i < 16; i++) if (SREG[i] == r) implBits |= 16'(f) << SLSB[i];
    endfunction : implBits
    // level of source i; can sources are dead on this variant
    function automatic logic [2:0] expLevel(int i);
        expLevel = (i == 4 || i == 5) ? 3'h0 : model[SREG[i]][SLSB[i] +: 3];
    endfunction : expLevel
    function automatic logic [15:0] expEn();
        for (int i = 0; i < 16; i++) expEn[i] = |expLevel(i);
    endfunction : expEn
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic checkLevels();
        for (int i = 0; i < 16; i++) check(32'(lv[i]), 32'(expLevel(i)));
        check(32'(srcEn), 32'(expEn()));
        check(32'(lvCan[0]), 32'(model[1][14:12]));
        check(32'(lvCan[1]), 32'(model[1][10:8]));
        check(32'(srcEnCan), 32'(expEn() | {10'h0, |model[1][10:8], |model[1][14:12], 4'h0}));
    endtask : checkLevels
    // each task starts one edge later, so no strobe is driven twice in a step
    task automatic axiWrite(input logic [6:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] resp);
        logic awDone, wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge clock);
        awAddr <= a;
        wData <= d;
        wStrb <= s;
        prot <= 3'($urandom);
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge clock);
            awDone |= awReady;
            wDone |= wReady;
            awValid <= !awDone;
            wValid <= !wDone;
        end
        do @(posedge clock); while (bValid !== 1'b1);
        resp = bResp;
        bReady <= 1'b0;
    endtask : axiWrite
    task automatic axiRead(input logic [6:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge clock);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do @(posedge clock); while (arReady !== 1'b1);
        arValid <= 1'b0;
        do @(posedge clock); while (rValid !== 1'b1);
        d = rData;
        resp = rResp;
        rReady <= 1'b0;
    endtask : axiRead
    task automatic writeReg(input int r, input logic [31:0] d, input logic [3:0] s);
        logic [1:0] resp;
        logic [15:0] lane;
        lane = {{8{s[1]}}, {8{s[0]}}};
        axiWrite(OFFS[r], d, s, resp);
        check(32'(resp), 32'h0);
        model[r] = (d[15:0] & lane & implBits(r, 3'h7)) | (model[r] & ~lane);
        checkLevels();
    endtask : writeReg
    task automatic checkReg(input int r);
        logic [31:0] d;
        logic [1:0] resp;
        axiRead(OFFS[r], d, resp);
        check(32'(resp), 32'h0);
        check(d, 32'(model[r]));
        check(rDataCan, 32'(model[r]));
    endtask : checkReg
    task automatic applyReset(input int n);
        srst <= 1'b1;
        repeat (n) @(posedge clock);
        srst <= 1'b0;
        for (int r = 0; r < 6; r++) model[r] = implBits(r, 3'h4);
    endtask : applyReset
    task automatic giveVerdict();
        if (failures == 0 && checksDone > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : giveVerdict
    initial begin
        forever #5 clock = ~clock;
    end
    // cut a hang short, well past the expected run of under a thousand cycles
    initial begin
        #200us;
        failures++;
        giveVerdict();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] resp;
        void'($urandom(44));
        applyReset(5);
        checkLevels();
        for (int r = 0; r < 6; r++) checkReg(r);
        // every code in every field, disabled and both ends included
        for (int c = 0; c < 8; c++) begin
            for (int r = 0; r < 6; r++) writeReg(r, {8{4'(c)}}, 4'hf);
        end
        writeReg(2, 32'hffff_ffff, 4'hf);
        checkReg(2);
        repeat (80) begin
            int r;
            r = $urandom_range(5);
            writeReg(r, $urandom, 4'($urandom));
            checkReg(r);
        end
        // unmapped, misaligned and read-only status places
        foreach (BAD[k]) begin
            axiWrite(BAD[k], 32'hffff_ffff, 4'hf, resp);
            check(32'(resp), 32'(BADR[k]));
            axiRead(BAD[k], d, resp);
            check(32'(resp), 32'(BADR[k]));
            check(d, BADR[k] == 2'h0 ? 32'(expEn()) : 32'h0);
            checkLevels();
        end
        applyReset(3);
        checkLevels();
        for (int r = 0; r < 6; r++) checkReg(r);
        giveVerdict();
    end
endmodule : ipb_priority_bank_bench
`default_nettype wire
